// ### logic/option_cfg_pkg.sv
`default_nettype none
package option_cfg_pkg;
  // ********************************************
  // Register map
  // ********************************************
  localparam logic [31:0] OFS_CFG0 = 32'h0000_0000;
  localparam logic [31:0] OFS_CFG1 = 32'h0000_0004;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0008;
  localparam logic [31:0] OFS_STAT = 32'h0000_000C;
  localparam logic [3:0] ADDR_MASK = 4'h0_00C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h0_2;
  localparam logic [1:0] HTRANS_SEQ = 2'h0_3;
  localparam logic [2:0] HSIZE_WORD = 3'h0_2;

  // ********************************************
  // Unprogrammed byte values
  // ********************************************
  localparam logic [7:0] CFG0_DEFAULT = 8'h00_FC;
  localparam logic [7:0] CFG1_DEFAULT = 8'h00_EF;

  // ********************************************
  // Field positions
  // ********************************************
  localparam int B0_RESERVED = 7;
  localparam int B0_RANGE_LSB = 4;
  localparam int B0_SIZE_LSB = 2;
  localparam int B0_ROP = 1;
  localparam int B0_WP = 0;
  localparam int B1_FACTOR = 7;
  localparam int B1_PLL_BYP = 6;
  localparam int B1_TPLL_BYP = 5;
  localparam int B1_RC_OFF = 4;
  localparam int B1_BO_LSB = 2;
  localparam int B1_WATCHDOG_SOFTWARE_MODE = 1;
  localparam int B1_WATCHDOG_RESET_ON_HALT = 0;
  localparam int CTRL_ERASE = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_ROP = 2;
  localparam int STAT_WP = 3;
  localparam int STAT_PROG = 4;

  // ********************************************
  // First block sizes in bytes
  // ********************************************
  localparam logic [12:0] SIZE_HALF_K = 13'h0_200;
  localparam logic [12:0] SIZE_1K = 13'h0_400;
  localparam logic [12:0] SIZE_2K = 13'h0_800;
  localparam logic [12:0] SIZE_4K = 13'h1_000;

  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [3:0] {
    low_power_range, medium_power_range, medium_speed_range,
    high_speed_range, very_low_power_range, external_clock_input_main,
    external_clock_input_alt, reserved_range, internal_rc
  } clock_source_t;

  typedef enum logic [1:0] {
    brownout_off, brownout_lowest, brownout_medium, brownout_highest
  } brownout_t;

  typedef struct packed {
    clock_source_t clock_source_range;
    logic [12:0] first_block_size;
    logic readout_protect;
    logic write_protect_lock;
    logic pll_factor_select;
    logic main_pll_bypass;
    logic timer_pll_bypass;
    logic internal_rc_off;
    brownout_t brownout_threshold_select;
    logic watchdog_software_mode;
    logic watchdog_reset_on_halt;
  } hw_settings_t;
endpackage
`default_nettype wire

// ### logic/config_capture.sv
`default_nettype none
module config_capture
  import option_cfg_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Stored bytes
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] held_out
);
  // Follow the array while reset is low, freeze afterwards
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      held_out <= raw_in;
    end
  end
endmodule
`default_nettype wire

// ### logic/config_decode.sv
`default_nettype none
module config_decode
  import option_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Captured bytes
  input wire logic [7:0] byte0_in,
  input wire logic [7:0] byte1_in,
  // Decoded settings
  output hw_settings_t settings_out
);
  // Turn two bytes into settings
  function automatic hw_settings_t decode(input logic [7:0] b0, input logic [7:0] b1);
    hw_settings_t s;
    s = '0;
    s.internal_rc_off = b1[B1_RC_OFF];
    unique case (b0[B0_RANGE_LSB +: 3])
      3'h0_0: s.clock_source_range = low_power_range;
      3'h0_1: s.clock_source_range = medium_power_range;
      3'h0_2: s.clock_source_range = medium_speed_range;
      3'h0_3: s.clock_source_range = high_speed_range;
      3'h0_4: s.clock_source_range = very_low_power_range;
      3'h0_5: s.clock_source_range = external_clock_input_main;
      3'h0_7: s.clock_source_range = external_clock_input_alt;
      default: s.clock_source_range = reserved_range;
    endcase
    if (!b1[B1_RC_OFF])
    begin
      s.clock_source_range = internal_rc;
    end
    unique case (b0[B0_SIZE_LSB +: 2])
      2'h0_0: s.first_block_size = SIZE_HALF_K;
      2'h0_1: s.first_block_size = SIZE_1K;
      2'h0_2: s.first_block_size = SIZE_2K;
      default: s.first_block_size = SIZE_4K;
    endcase
    s.readout_protect = b0[B0_ROP];
    s.write_protect_lock = b0[B0_WP];
    s.pll_factor_select = b1[B1_FACTOR];
    s.main_pll_bypass = b1[B1_PLL_BYP];
    s.timer_pll_bypass = b1[B1_TPLL_BYP];
    unique case (b1[B1_BO_LSB +: 2])
      2'h0_3: s.brownout_threshold_select = brownout_off;
      2'h0_0: s.brownout_threshold_select = brownout_lowest;
      2'h0_1: s.brownout_threshold_select = brownout_medium;
      default: s.brownout_threshold_select = brownout_highest;
    endcase
    s.watchdog_software_mode = b1[B1_WATCHDOG_SOFTWARE_MODE];
    s.watchdog_reset_on_halt = b1[B1_WATCHDOG_RESET_ON_HALT];
    return s;
  endfunction

  // Registered settings, defaults during reset
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      settings_out <= decode(CFG0_DEFAULT, CFG1_DEFAULT);
    end
    else
    begin
      settings_out <= decode(byte0_in, byte1_in);
    end
  end
endmodule
`default_nettype wire

// ### logic/option_byte_config_decoder.sv
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`default_nettype none
module option_byte_config_decoder
  import option_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Non-volatile byte array
  input wire logic [7:0] nv_byte0_in,
  input wire logic [7:0] nv_byte1_in,
  input wire logic nv_write_done_in,
  output logic nv_write_req_out,
  output logic nv_write_sel_out,
  output logic [7:0] nv_write_data_out,
  // Program memory control
  input wire logic mem_erase_done_in,
  output logic mem_erase_req_out,
  output logic program_read_block_out,
  output logic program_write_block_out,
  // Mode and watchdog
  input wire logic prog_mode_in,
  input wire logic watchdog_sw_enable_in,
  input wire logic halt_entry_in,
  output logic halt_reset_out,
  // Decoded settings
  output hw_settings_t settings_out
);
  // ********************************************
  // Declarations
  // ********************************************
  typedef enum logic [2:0] {
    st_idle, st_write, st_mem_erase, st_erase0, st_erase1
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [15:0] held_bytes;
  logic wr_pend_q;
  logic [3:0] wr_addr_q;
  logic rd_sel;
  logic [31:0] rd_data;
  logic wr_fire;
  logic cfg_write;
  logic erase_cmd;
  logic refused_set;
  logic refused_q;
  logic refused_clr;
  logic wp_lock_q;
  logic wp_live;
  logic rop_live;
  logic wdg_active;
  logic word_ok;

  // ********************************************
  // Capture and decode
  // ********************************************
  config_capture #(
    .WIDTH(16)
  ) u_capture (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .raw_in({nv_byte1_in, nv_byte0_in}),
    .held_out(held_bytes)
  );

  config_decode u_decode (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .byte0_in(held_bytes[7:0]),
    .byte1_in(held_bytes[15:8]),
    .settings_out(settings_out)
  );

  // ********************************************
  // Bus slave
  // ********************************************
  // Address phase qualifiers
  assign word_ok = (hsize_in == HSIZE_WORD);
  assign rd_sel = hsel_in && hready_in && htrans_in[1] && !hwrite_in;

  // Zero wait states, always OKAY
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // Remember a write address phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0_0;
    end
    else
    begin
      wr_pend_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in && word_ok;
      wr_addr_q <= haddr_in[3:0] & ADDR_MASK;
    end
  end

  // Read mux; config bytes hidden outside programming mode
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (haddr_in[3:0] & ADDR_MASK)
      OFS_CFG0[3:0]: rd_data[7:0] = prog_mode_in ? nv_byte0_in : 8'h00_00;
      OFS_CFG1[3:0]: rd_data[7:0] = prog_mode_in ? nv_byte1_in : 8'h00_00;
      OFS_CTRL[3:0]: rd_data = 32'h0000_0000;
      default:
      begin
        rd_data[STAT_BUSY] = (state_q != st_idle);
        rd_data[STAT_REFUSED] = refused_q;
        rd_data[STAT_ROP] = settings_out.readout_protect;
        rd_data[STAT_WP] = wp_lock_q;
        rd_data[STAT_PROG] = prog_mode_in;
      end
    endcase
  end

  // Read data registered for the data phase
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      hrdata_out <= 32'h0000_0000;
    end
    else if (rd_sel)
    begin
      hrdata_out <= word_ok ? rd_data : 32'h0000_0000;
    end
  end

  // ********************************************
  // Write decode and refusal
  // ********************************************
  assign wr_fire = wr_pend_q;
  assign cfg_write = wr_fire &&
    (wr_addr_q == OFS_CFG0[3:0] || wr_addr_q == OFS_CFG1[3:0]);
  assign erase_cmd = wr_fire && (wr_addr_q == OFS_CTRL[3:0]) && hwdata_in[CTRL_ERASE];
  assign refused_clr = wr_fire && (wr_addr_q == OFS_STAT[3:0]) && hwdata_in[STAT_REFUSED];
  assign wp_live = wp_lock_q || nv_byte0_in[B0_WP];
  assign rop_live = nv_byte0_in[B0_ROP];

  // Why a command is refused
  always_comb
  begin
    refused_set = 1'b0;
    if (cfg_write || erase_cmd)
    begin
      if (!prog_mode_in)
      begin
        refused_set = 1'b1;
      end
      else if (wp_live)
      begin
        refused_set = 1'b1;
      end
      else if (state_q != st_idle)
      begin
        refused_set = 1'b1;
      end
      else if (cfg_write && rop_live)
      begin
        refused_set = 1'b1;
      end
    end
  end

  // Sticky refusal flag, set wins over clear
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      refused_q <= 1'b0;
    end
    else if (refused_set)
    begin
      refused_q <= 1'b1;
    end
    else if (refused_clr)
    begin
      refused_q <= 1'b0;
    end
  end

  // Write protection is permanent once seen
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      wp_lock_q <= 1'b0;
    end
    else if (settings_out.write_protect_lock || nv_byte0_in[B0_WP])
    begin
      wp_lock_q <= 1'b1;
    end
  end

  // ********************************************
  // Programming sequencer
  // ********************************************
  // Next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      st_idle:
      begin
        if (!refused_set && cfg_write)
        begin
          state_d = st_write;
        end
        else if (!refused_set && erase_cmd)
        begin
          state_d = rop_live ? st_mem_erase : st_erase0;
        end
      end
      st_write:
      begin
        if (nv_write_done_in)
        begin
          state_d = st_idle;
        end
      end
      st_mem_erase:
      begin
        if (mem_erase_done_in)
        begin
          state_d = st_erase0;
        end
      end
      st_erase0:
      begin
        if (nv_write_done_in)
        begin
          state_d = st_erase1;
        end
      end
      st_erase1:
      begin
        if (nv_write_done_in)
        begin
          state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      state_q <= st_idle;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Requests to the byte array and program memory
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      nv_write_req_out <= 1'b0;
      nv_write_sel_out <= 1'b0;
      nv_write_data_out <= 8'h00_00;
      mem_erase_req_out <= 1'b0;
    end
    else
    begin
      nv_write_req_out <= (state_d == st_write) || (state_d == st_erase0) ||
        (state_d == st_erase1);
      mem_erase_req_out <= (state_d == st_mem_erase);
      if (state_q == st_idle && state_d == st_write)
      begin
        nv_write_sel_out <= (wr_addr_q == OFS_CFG1[3:0]);
        nv_write_data_out <= hwdata_in[7:0];
      end
      else if (state_q != st_erase0 && state_d == st_erase0)
      begin
        nv_write_sel_out <= 1'b0;
        nv_write_data_out <= CFG0_DEFAULT;
      end
      else if (state_q == st_erase0 && state_d == st_erase1)
      begin
        nv_write_sel_out <= 1'b1;
        nv_write_data_out <= CFG1_DEFAULT;
      end
    end
  end

  // ********************************************
  // Protection and watchdog outputs
  // ********************************************
  assign wdg_active = !settings_out.watchdog_software_mode || watchdog_sw_enable_in;

  // Program memory blocking
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      program_read_block_out <= 1'b0;
      program_write_block_out <= 1'b0;
    end
    else
    begin
      program_read_block_out <= settings_out.readout_protect;
      program_write_block_out <= settings_out.readout_protect || wp_lock_q;
    end
  end

  // Halt entry reset request
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      halt_reset_out <= 1'b0;
    end
    else
    begin
      halt_reset_out <= halt_entry_in && wdg_active &&
        settings_out.watchdog_reset_on_halt;
    end
  end
endmodule
`default_nettype wire

// ### test/cfg_decoder_asserts.sv
`default_nettype none
module cfg_decoder_asserts
  import option_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  // Memory side
  input wire logic nv_write_req_out,
  input wire logic mem_erase_req_out,
  input wire logic mem_erase_done_in,
  input wire logic program_read_block_out,
  input wire logic program_write_block_out,
  // Mode and watchdog
  input wire logic prog_mode_in,
  input wire logic watchdog_sw_enable_in,
  input wire logic halt_entry_in,
  input wire logic halt_reset_out,
  input wire hw_settings_t settings_out
);
  // ****
  // Checks
  // ****
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [1:0] up_q;
  logic wd_on;
  // Edges since reset release, saturating
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  // Watchdog running
  assign wd_on = !settings_out.watchdog_software_mode || watchdog_sw_enable_in;
  sequence taken;
    hsel_in && hready_in && htrans_in[1];
  endsequence
  sequence cfg_wr;
    taken ##0 hwrite_in && !haddr_in[3] && !nv_write_req_out && !mem_erase_req_out;
  endsequence
  sequence cfg_rd;
    taken ##0 !hwrite_in && !haddr_in[3];
  endsequence
  sequence ctrl_wr;
    taken ##0 hwrite_in && haddr_in[3:2] == 2'h2;
  endsequence
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  ready_up_a: assert property (up_q != 2'h0 |-> hreadyout_out)
    else $error("bus not ready after reset");
  settings_hold_a: assert property (up_q[1] |-> $stable(settings_out))
    else $error("settings changed without reset");
  read_block_a: assert property (up_q[1] |-> program_read_block_out == settings_out.readout_protect)
    else $error("read block differs from readout bit");
  write_block_a: assert property (up_q[1] && (settings_out.readout_protect ||
    settings_out.write_protect_lock) |-> program_write_block_out)
    else $error("program writes not blocked");
  halt_reset_a: assert property (up_q[1] && halt_entry_in &&
    settings_out.watchdog_reset_on_halt && wd_on |=> halt_reset_out)
    else $error("halt entry gave no reset");
  halt_quiet_a: assert property (up_q[1] && halt_entry_in &&
    !(settings_out.watchdog_reset_on_halt && wd_on) |=> !halt_reset_out)
    else $error("halt entry gave an unexpected reset");
  erase_hold_a: assert property (mem_erase_req_out && !mem_erase_done_in |=> mem_erase_req_out)
    else $error("erase request dropped early");
  cfg_refuse_a: assert property (cfg_wr ##0 !prog_mode_in |=> !nv_write_req_out [*3])
    else $error("config write outside programming mode");
  cfg_hidden_a: assert property (cfg_rd ##0 !prog_mode_in |=> hrdata_out == 32'h0000_0000)
    else $error("config visible outside programming mode");
  erase_refuse_a: assert property (ctrl_wr ##0 settings_out.write_protect_lock
    |=> !mem_erase_req_out [*3])
    else $error("erase started under write lock");
endmodule
bind option_byte_config_decoder cfg_decoder_asserts cfg_decoder_asserts_i (.ref_clk_in,
  .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
  .hresp_out, .hrdata_out, .nv_write_req_out, .mem_erase_req_out, .mem_erase_done_in,
  .program_read_block_out, .program_write_block_out, .prog_mode_in, .watchdog_sw_enable_in,
  .halt_entry_in, .halt_reset_out, .settings_out);
`default_nettype wire

// ### test/nv_array_model.sv
`default_nettype none
module nv_array_model
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Device side
  input wire logic nv_write_req_in,
  input wire logic nv_write_sel_in,
  input wire logic [7:0] nv_write_data_in,
  input wire logic mem_erase_req_in,
  input wire logic [3:0] lat_in,
  output logic [7:0] byte0_out,
  output logic [7:0] byte1_out,
  output logic write_done_out,
  output logic erase_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Byte store
  // ****
  logic [3:0] wcnt_q;
  logic [3:0] ecnt_q;
  // Writes and erase end after lat_in + 1 cycles; a done cycle is never repeated
  always @(posedge ref_clk_in)
  begin
    write_done_out <= 1'b0;
    erase_done_out <= 1'b0;
    if (!resetn_in || !nv_write_req_in || write_done_out)
      wcnt_q <= 4'h0;
    else if (wcnt_q == lat_in)
    begin
      write_done_out <= 1'b1;
      if (nv_write_sel_in)
        byte1_out <= nv_write_data_in;
      else
        byte0_out <= nv_write_data_in;
    end
    else
      wcnt_q <= wcnt_q + 4'h1;
    if (!resetn_in || !mem_erase_req_in || erase_done_out)
      ecnt_q <= 4'h0;
    else if (ecnt_q == lat_in)
      erase_done_out <= 1'b1;
    else
      ecnt_q <= ecnt_q + 4'h1;
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`default_nettype none
module tb_top
  import option_cfg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Bench
  // ****
  logic ref_clk_in, resetn_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic [7:0] nv_byte0_in, nv_byte1_in, nv_write_data_out;
  logic nv_write_done_in, nv_write_req_out, nv_write_sel_out, mem_erase_done_in;
  logic mem_erase_req_out, program_read_block_out, program_write_block_out;
  logic prog_mode_in, watchdog_sw_enable_in, halt_entry_in, halt_reset_out, erase_seen;
  hw_settings_t settings_out;
  logic [3:0] lat;
  logic [15:0] seed;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  option_byte_config_decoder option_byte_config_decoder_i (.ref_clk_in, .resetn_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out),
    .hreadyout_out, .hresp_out, .hrdata_out, .nv_byte0_in, .nv_byte1_in, .nv_write_done_in,
    .nv_write_req_out, .nv_write_sel_out, .nv_write_data_out, .mem_erase_done_in,
    .mem_erase_req_out, .program_read_block_out, .program_write_block_out, .prog_mode_in,
    .watchdog_sw_enable_in, .halt_entry_in, .halt_reset_out, .settings_out);
  nv_array_model nv_array_model_i (.ref_clk_in, .resetn_in, .nv_write_req_in(nv_write_req_out),
    .nv_write_sel_in(nv_write_sel_out), .nv_write_data_in(nv_write_data_out),
    .mem_erase_req_in(mem_erase_req_out), .lat_in(lat), .byte0_out(nv_byte0_in),
    .byte1_out(nv_byte1_in), .write_done_out(nv_write_done_in),
    .erase_done_out(mem_erase_done_in));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic hw_settings_t decode(input logic [7:0] b0, input logic [7:0] b1);
    clock_source_t r [8] = '{low_power_range, medium_power_range, medium_speed_range,
      high_speed_range, very_low_power_range, external_clock_input_main, reserved_range,
      external_clock_input_alt};
    brownout_t bo [4] = '{brownout_lowest, brownout_medium, brownout_highest, brownout_off};
    decode = {b1[4] ? r[b0[6:4]] : internal_rc, SIZE_HALF_K << b0[3:2], b0[1:0], b1[7:4],
      bo[b1[3:2]], b1[1:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge ref_clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= wr;
    hsize_in <= HSIZE_WORD;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h0000_0001;
    while (s[STAT_BUSY] !== 1'b0)
      bus(1'b0, OFS_STAT, 32'h0000_0000, s);
  endtask
  task automatic reboot(input logic [7:0] b0, input logic [7:0] b1, input int n);
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    nv_array_model_i.byte0_out <= b0;
    nv_array_model_i.byte1_out <= b1;
    repeat (n) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    check("settings", settings_out, decode(b0, b1));
    // Block outputs follow the decoded settings one edge later
    @(posedge ref_clk_in);
    #1;
    check("read block", program_read_block_out, b0[1]);
    check("write block", program_write_block_out, b0[1] | b0[0]);
  endtask
  task automatic halt(input logic [7:0] b1, input logic en);
    @(posedge ref_clk_in);
    watchdog_sw_enable_in <= en;
    halt_entry_in <= 1'b1;
    @(posedge ref_clk_in);
    halt_entry_in <= 1'b0;
    #1;
    check("halt reset", halt_reset_out, b1[0] & (!b1[1] | en));
  endtask
  // Clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Timeout and erase monitor
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (mem_erase_req_out === 1'b1)
      erase_seen = 1'b1;
    if (cyc == 20000)
    begin
      miscompares++;
      results;
    end
  end
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [7:0] b0, b1;
    {resetn_in, hsel_in, hwrite_in, prog_mode_in, watchdog_sw_enable_in, halt_entry_in} = 6'h00;
    {haddr_in, hwdata_in, htrans_in, hsize_in} = '0;
    lat = 4'h2;
    seed = 16'h3C26;
    erase_seen = 1'b0;
    reboot(CFG0_DEFAULT, CFG1_DEFAULT, 16);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      b0 = seed[7:0] | 8'h80;
      seed = lfsr(seed);
      b1 = seed[7:0];
      if (i < 8)
        {b0[6:4], b1[4]} = {i[2:0], 1'b1};
      if (!b1[4])
        b0[6:4] = 3'h7;
      b0[0] = 1'b0;
      lat <= seed[11:8];
      reboot(b0, b1, 3);
      halt(b1, seed[12]);
      halt(b1, !seed[12]);
    end
    prog_mode_in <= 1'b1;
    reboot(CFG0_DEFAULT, CFG1_DEFAULT, 3);
    bus(1'b1, OFS_CFG1, 32'h0000_006F, d);
    wait_idle;
    bus(1'b0, OFS_CFG1, 32'h0000_0000, d);
    check("cfg one readback", d, 32'h0000_006F);
    check("array byte one", nv_byte1_in, 8'h6F);
    check("settings frozen", settings_out, decode(CFG0_DEFAULT, CFG1_DEFAULT));
    reboot(CFG0_DEFAULT, 8'h6F, 3);
    prog_mode_in <= 1'b0;
    bus(1'b1, OFS_CFG0, 32'h0000_00F0, d);
    bus(1'b0, OFS_STAT, 32'h0000_0000, d);
    check("refused flag", d[STAT_REFUSED], 1'b1);
    check("array byte zero", nv_byte0_in, CFG0_DEFAULT);
    bus(1'b0, OFS_CFG0, 32'h0000_0000, d);
    check("hidden cfg", d, 32'h0000_0000);
    bus(1'b1, OFS_STAT, 32'h0000_0002, d);
    bus(1'b0, OFS_STAT, 32'h0000_0000, d);
    check("refused cleared", d[STAT_REFUSED], 1'b0);
    prog_mode_in <= 1'b1;
    reboot(8'hFE, CFG1_DEFAULT, 3);
    bus(1'b1, OFS_CFG0, 32'h0000_00FC, d);
    bus(1'b0, OFS_STAT, 32'h0000_0000, d);
    check("readout refuses", d[STAT_REFUSED], 1'b1);
    bus(1'b1, OFS_CTRL, 32'h0000_0001, d);
    wait_idle;
    check("erase issued", erase_seen, 1'b1);
    check("erased byte zero", nv_byte0_in, CFG0_DEFAULT);
    check("erased byte one", nv_byte1_in, CFG1_DEFAULT);
    reboot(8'hFD, CFG1_DEFAULT, 3);
    erase_seen = 1'b0;
    bus(1'b1, OFS_STAT, 32'h0000_0002, d);
    bus(1'b1, OFS_CTRL, 32'h0000_0001, d);
    bus(1'b0, OFS_STAT, 32'h0000_0000, d);
    check("lock refuses", d[STAT_REFUSED], 1'b1);
    check("lock status", d[STAT_WP], 1'b1);
    check("no erase", erase_seen, 1'b0);
    results;
  end
endmodule
`default_nettype wire
